// ==== dag_addr_gen.sv ====
/*
  Effective-address generator for the core's 12-bit data space: three
  pointer pairs, their virtual ports and the extended indexed window.
  Assumes the core presents one operand access per cycle at most and
  that the data RAM answers a read in the same cycle as the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module dag_addr_gen
  import dag_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              extended_ops_cfg_in,
  input  wire logic [BANK_W-1:0] bank_page_reg_in,
  input  wire logic [DATA_W-1:0] acc_in,
  input  wire logic              op_valid_in,
  input  wire logic              op_write_in,
  input  wire logic              op_bank_bit_in,
  input  wire logic [7:0]        op_file_in,
  input  wire logic              op_long_in,
  input  wire logic [ADDR_W-1:0] op_long_addr_in,
  input  wire logic [DATA_W-1:0] op_wdata_in,
  input  wire logic [DATA_W-1:0] mem_rdata_in,
  output logic      [ADDR_W-1:0] mem_addr_out,
  output logic                   mem_rd_out,
  output logic                   mem_wr_out,
  output logic      [DATA_W-1:0] mem_wdata_out,
  output logic                   rsp_valid_out,
  output logic      [DATA_W-1:0] rsp_data_out,
  output logic      [ADDR_W-1:0] pointer_pair_zero_out,
  output logic      [ADDR_W-1:0] pointer_pair_one_out,
  output logic      [ADDR_W-1:0] pointer_pair_two_out
);
  function automatic dag_pair_t pair_of(input logic [ADDR_W-1:0] addr);
    dag_pair_t p;
    p = PAIR_NONE;
    if (addr[2:0] != SLOT_OTHER)
    begin
      case (addr[11:3])
        PAIR0_BLOCK: p = PAIR_ZERO;
        PAIR1_BLOCK: p = PAIR_ONE;
        PAIR2_BLOCK: p = PAIR_TWO;
        default:     p = PAIR_NONE;
      endcase
    end
    return p;
  endfunction

  function automatic logic is_virtual(input logic [ADDR_W-1:0] addr);
    return (pair_of(addr) != PAIR_NONE) && (addr[2:0] >= SLOT_OFFSET);
  endfunction

  function automatic logic is_ptr_reg(input logic [ADDR_W-1:0] addr);
    return (pair_of(addr) != PAIR_NONE) && (addr[2:0] < SLOT_OFFSET);
  endfunction

  function automatic logic [ADDR_W-1:0] pick(
    input dag_pair_t              p,
    input logic [2:0][ADDR_W-1:0] all);
    logic [ADDR_W-1:0] v;
    v = all[2];
    if (p == PAIR_ZERO)
      v = all[0];
    else if (p == PAIR_ONE)
      v = all[1];
    return v;
  endfunction

  logic [2:0][ADDR_W-1:0] ptr_all;
  logic [2:0]             load_lo;
  logic [2:0]             load_hi;
  logic [2:0]             step;
  logic                   indexed;
  logic [ADDR_W-1:0]      base_addr;
  dag_pair_t              d_pair;
  dag_slot_t              d_slot;
  logic [1:0]             d_idx;
  logic                   d_virt;
  logic [ADDR_W-1:0]      sel_ptr;
  logic [ADDR_W-1:0]      acc_ext;
  logic [ADDR_W-1:0]      eff_addr;
  dag_pair_t              e_pair;
  dag_slot_t              e_slot;
  logic [ADDR_W-1:0]      e_ptr;
  logic                   null_acc;
  logic                   ptr_hit;
  logic                   mem_go;
  logic                   wr_ptr;
  logic                   modifying;
  logic                   block_step;
  logic                   step_down;
  logic [DATA_W-1:0]      ptr_byte;

  logic [ADDR_W-1:0]      mem_addr_q;
  logic                   mem_rd_q;
  logic                   mem_wr_q;
  logic [DATA_W-1:0]      mem_wdata_q;
  logic                   pend_q;
  dag_src_t               src_q;
  logic [DATA_W-1:0]      hold_q;
  logic                   rsp_valid_q;
  logic [DATA_W-1:0]      rsp_data_q;

  assign indexed = extended_ops_cfg_in && !op_long_in && !op_bank_bit_in
                 && (op_file_in <= INDEX_LIMIT);

  assign base_addr = op_long_in     ? op_long_addr_in
                   : op_bank_bit_in ? {bank_page_reg_in, op_file_in}
                   : indexed        ? ADDR_W'(ptr_all[2] + {4'h0, op_file_in})
                   : (op_file_in > INDEX_LIMIT)
                                    ? {ACCESS_HI_PAGE, op_file_in}
                                    : {ACCESS_LO_PAGE, op_file_in};

  assign d_pair = pair_of(base_addr);
  assign d_slot = dag_slot_t'(base_addr[2:0]);
  assign d_idx  = d_pair;

  assign d_virt = !indexed && is_virtual(base_addr);

  assign sel_ptr = pick(d_pair, ptr_all);
  assign acc_ext = {{4{acc_in[7]}}, acc_in};

  assign eff_addr = !d_virt                  ? base_addr
                  : (d_slot == SLOT_INCREMENT_THEN_DEREF_PORT)  ? ADDR_W'(sel_ptr + PTR_ONE)
                  : (d_slot == SLOT_OFFSET)  ? ADDR_W'(sel_ptr + acc_ext)
                  : sel_ptr;

  assign e_pair = pair_of(eff_addr);
  assign e_slot = dag_slot_t'(eff_addr[2:0]);
  assign e_ptr  = pick(e_pair, ptr_all);

  assign null_acc = is_virtual(eff_addr);
  assign ptr_hit  = is_ptr_reg(eff_addr);
  assign mem_go   = op_valid_in && !null_acc && !ptr_hit;

  assign wr_ptr = op_valid_in && op_write_in && ptr_hit;

  assign modifying = op_valid_in && d_virt
                   && ((d_slot == SLOT_INCREMENT_THEN_DEREF_PORT) || (d_slot == SLOT_DEREF_THEN_DECREMENT_PORT)
                       || (d_slot == SLOT_DEREF_THEN_INCREMENT_PORT));

  assign block_step = wr_ptr && (e_pair == d_pair);
  assign step_down  = (d_slot == SLOT_DEREF_THEN_DECREMENT_PORT);

  // High byte reads back with its unused nibble as zero.
  assign ptr_byte = (e_slot == SLOT_HIGH) ? {HIGH_PAD, e_ptr[11:8]} : e_ptr[7:0];

  for (genvar g = 0; g < PAIR_COUNT; g++)
  begin : g_pair
    assign load_lo[g] = wr_ptr && (e_pair == dag_pair_t'(g)) && (e_slot == SLOT_LOW);
    assign load_hi[g] = wr_ptr && (e_pair == dag_pair_t'(g)) && (e_slot == SLOT_HIGH);
    assign step[g]    = modifying && !block_step && (d_pair == dag_pair_t'(g));

    dag_ptr_pair u_pair
    (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .load_lo_in   (load_lo[g]),
      .load_hi_in   (load_hi[g]),
      .data_in      (op_wdata_in),
      .step_in      (step[g]),
      .step_down_in (step_down),
      .value_out    (ptr_all[g])
    );
  end

  // The memory side is registered so the address path never reaches the
  // RAM pins through the pointer adders in the same cycle.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mem_addr_q  <= PTR_RESET;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= NULL_DATA;
      pend_q      <= 1'b0;
      src_q       <= SRC_MEM;
      hold_q      <= NULL_DATA;
    end
    else
    begin
      mem_rd_q <= mem_go && !op_write_in;
      mem_wr_q <= mem_go && op_write_in;
      pend_q   <= op_valid_in && !op_write_in;
      if (mem_go)
      begin
        mem_addr_q  <= eff_addr;
        mem_wdata_q <= op_wdata_in;
      end
      if (op_valid_in)
      begin
        src_q  <= mem_go ? SRC_MEM : SRC_HOLD;
        hold_q <= null_acc ? NULL_DATA : ptr_byte;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= NULL_DATA;
    end
    else
    begin
      rsp_valid_q <= pend_q;
      if (pend_q)
        rsp_data_q <= (src_q == SRC_MEM) ? mem_rdata_in : hold_q;
    end
  end

  assign mem_addr_out          = mem_addr_q;
  assign mem_rd_out            = mem_rd_q;
  assign mem_wr_out            = mem_wr_q;
  assign mem_wdata_out         = mem_wdata_q;
  assign rsp_valid_out         = rsp_valid_q;
  assign rsp_data_out          = rsp_data_q;
  assign pointer_pair_zero_out = ptr_all[0];
  assign pointer_pair_one_out  = ptr_all[1];
  assign pointer_pair_two_out  = ptr_all[2];

  deref_hold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (op_valid_in && d_virt && (d_slot == SLOT_DEREF) && !wr_ptr)
    |=> (ptr_all[$past(d_idx)] == $past(sel_ptr)))
    else $error("plain dereference changed its pointer");

  deref_addr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mem_go && d_virt && (d_slot == SLOT_DEREF))
    |=> (mem_rd_out || mem_wr_out) && (mem_addr_out == $past(sel_ptr)))
    else $error("pointer access did not use the pointer value");

  deref_then_decrement_port_step_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (op_valid_in && d_virt && (d_slot == SLOT_DEREF_THEN_DECREMENT_PORT) && !block_step)
    |=> (ptr_all[$past(d_idx)] == ADDR_W'($past(sel_ptr) - PTR_ONE)))
    else $error("post-decrement did not subtract one");

  deref_then_increment_port_step_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mem_go && d_virt && (d_slot == SLOT_DEREF_THEN_INCREMENT_PORT) && !block_step)
    |=> (mem_addr_out == $past(sel_ptr))
        && (ptr_all[$past(d_idx)] == ADDR_W'($past(sel_ptr) + PTR_ONE)))
    else $error("post-increment address or step wrong");

  increment_then_deref_port_addr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mem_go && d_virt && (d_slot == SLOT_INCREMENT_THEN_DEREF_PORT))
    |=> (mem_addr_out == ptr_all[$past(d_idx)]))
    else $error("pre-increment did not address the raised pointer");

  offset_addr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mem_go && d_virt && (d_slot == SLOT_OFFSET))
    |=> (mem_addr_out == ADDR_W'($past(sel_ptr) + $past(acc_ext)))
        && (ptr_all[$past(d_idx)] == $past(sel_ptr)))
    else $error("offset access wrong or pointer moved");

  null_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (op_valid_in && null_acc && !op_write_in)
    |-> ##1 !mem_rd_out && !mem_wr_out ##1 rsp_valid_out && (rsp_data_out == NULL_DATA))
    else $error("virtual target did not read as zero");

  self_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (modifying && block_step && (e_slot == SLOT_LOW))
    |=> (ptr_all[$past(d_idx)][7:0] == $past(op_wdata_in)))
    else $error("self write was stepped");

  bank_addr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mem_go && op_bank_bit_in && !op_long_in && !d_virt)
    |=> (mem_addr_out == {$past(bank_page_reg_in), $past(op_file_in)}))
    else $error("bank-page address wrong");

  indexed_addr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mem_go && indexed)
    |=> (mem_addr_out == ADDR_W'($past(ptr_all[2]) + {4'h0, $past(op_file_in)})))
    else $error("indexed address wrong");

  idle_stable_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !op_valid_in |=> $stable(ptr_all))
    else $error("pointer changed without an access");
endmodule
`default_nettype wire

// ==== dag_pkg.sv ====
/*
  Shared constants and types for the data address generator.
  Assumes a 12-bit data space with byte-wide data.
*/
`default_nettype none
package dag_pkg;
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned BANK_W         = 4;
  localparam int unsigned PAIR_COUNT     = 3;
  localparam logic [7:0]  INDEX_LIMIT    = 8'h5F;
  localparam logic [3:0]  ACCESS_HI_PAGE = 4'hF;
  localparam logic [3:0]  ACCESS_LO_PAGE = 4'h0;
  localparam logic [8:0]  PAIR0_BLOCK    = 9'h1FD;
  localparam logic [8:0]  PAIR1_BLOCK    = 9'h1FC;
  localparam logic [8:0]  PAIR2_BLOCK    = 9'h1FB;
  localparam logic [11:0] PTR_RESET      = 12'h000;
  localparam logic [11:0] PTR_ONE        = 12'h001;
  localparam logic [7:0]  NULL_DATA      = 8'h00;
  localparam logic [3:0]  HIGH_PAD       = 4'h0;

  typedef enum logic [2:0]
  {
    SLOT_OTHER   = 3'b000,
    SLOT_LOW     = 3'b001,
    SLOT_HIGH    = 3'b010,
    SLOT_OFFSET  = 3'b011,
    SLOT_INCREMENT_THEN_DEREF_PORT  = 3'b100,
    SLOT_DEREF_THEN_DECREMENT_PORT = 3'b101,
    SLOT_DEREF_THEN_INCREMENT_PORT = 3'b110,
    SLOT_DEREF   = 3'b111
  } dag_slot_t;

  typedef enum logic [1:0]
  {
    PAIR_ZERO = 2'b00,
    PAIR_ONE  = 2'b01,
    PAIR_TWO  = 2'b10,
    PAIR_NONE = 2'b11
  } dag_pair_t;

  typedef enum logic [0:0]
  {
    SRC_MEM  = 1'b0,
    SRC_HOLD = 1'b1
  } dag_src_t;
endpackage
`default_nettype wire

// ==== dag_ptr_pair.sv ====
/*
  One pointer pair: a 12-bit register loaded bytewise or stepped by one.
  Assumes the caller never loads and steps the same pair in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module dag_ptr_pair
  import dag_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              load_lo_in,
  input  wire logic              load_hi_in,
  input  wire logic [7:0]        data_in,
  input  wire logic              step_in,
  input  wire logic              step_down_in,
  output logic      [ADDR_W-1:0] value_out
);
  logic [ADDR_W-1:0] value_q;
  logic [ADDR_W-1:0] value_d;
  logic [ADDR_W-1:0] stepped;

  assign stepped = step_down_in ? ADDR_W'(value_q - PTR_ONE)
                                : ADDR_W'(value_q + PTR_ONE);

  assign value_d = load_hi_in ? {data_in[3:0], value_q[7:0]}
                 : load_lo_in ? {value_q[11:8], data_in}
                 : step_in    ? stepped
                 : value_q;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      value_q <= PTR_RESET;
    else
      value_q <= value_d;
  end

  assign value_out = value_q;
endmodule
`default_nettype wire

// ==== dag_ram_model.sv ====
/*
  Behavioural data RAM that faces the address generator.
  Assumes each read is answered in the same cycle as its read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module dag_ram_model
  import dag_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              rd_in,
  input  wire logic              wr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output logic      [DATA_W-1:0] rdata_out
);
  logic [DATA_W-1:0] mem [0:4095];
  logic [DATA_W-1:0] last_q;

  initial
  begin
    for (int i = 0; i < 4096; i++)
    begin
      mem[i] = 8'(i) ^ {2{4'(i >> 8)}};
    end
    last_q = 8'h00;
  end

  // Outside a read the bus shows the inverse of the last value, so a late sample is caught.
  assign rdata_out = rd_in ? mem[addr_in] : ~last_q;

  always @(posedge clk_in)
  begin
    if (rd_in)
    begin
      last_q <= mem[addr_in];
    end
    if (wr_in)
    begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
  Self-checking testbench for the data address generator.
  Assumes the generator's timing is one cycle to the strobe and two to the answer.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dag_pkg::*;
  logic        clk_in;
  logic        rst_n_in;
  logic        ext_in;
  logic [3:0]  page_in;
  logic [7:0]  acc_in;
  logic        op_valid_in;
  logic        op_write_in;
  logic        op_bank_bit_in;
  logic [7:0]  op_file_in;
  logic [7:0]  op_wdata_in;
  logic        op_long_in;
  logic [11:0] op_long_addr_in;
  logic [7:0]  mem_rdata_in;
  logic [11:0] mem_addr_out;
  logic        mem_rd_out;
  logic        mem_wr_out;
  logic [7:0]  mem_wdata_out;
  logic        rsp_valid_out;
  logic [7:0]  rsp_data_out;
  logic [11:0] ptr0;
  logic [11:0] ptr1;
  logic [11:0] ptr2;
  int          n_errors;
  int          checked;

  dag_addr_gen dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .extended_ops_cfg_in(ext_in),
    .bank_page_reg_in(page_in), .acc_in(acc_in), .op_valid_in(op_valid_in),
    .op_write_in(op_write_in), .op_bank_bit_in(op_bank_bit_in), .op_file_in(op_file_in),
    .op_long_in(op_long_in), .op_long_addr_in(op_long_addr_in), .op_wdata_in(op_wdata_in),
    .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .pointer_pair_zero_out(ptr0),
    .pointer_pair_one_out(ptr1), .pointer_pair_two_out(ptr2));

  dag_ram_model ram (.clk_in(clk_in), .addr_in(mem_addr_out), .rd_in(mem_rd_out),
    .wr_in(mem_wr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic setcfg(input logic x, input logic [3:0] pg, input logic [7:0] w);
    @(posedge clk_in);
    ext_in  <= x;
    page_in <= pg;
    acc_in  <= w;
  endtask

  // Selects or leaves the full-address form for the accesses that follow.
  task automatic set_long(input logic l, input logic [11:0] la);
    @(posedge clk_in);
    op_long_in      <= l;
    op_long_addr_in <= la;
  endtask

  // One operand access; hit says whether a RAM strobe must appear.
  task automatic do_op(input logic wr, input logic a, input logic [7:0] f, input logic [7:0] wd,
                       input logic hit, input logic [11:0] ea, input logic [7:0] rd);
    @(posedge clk_in);
    op_valid_in    <= 1'b1;
    op_write_in    <= wr;
    op_bank_bit_in <= a;
    op_file_in     <= f;
    op_wdata_in    <= wd;
    @(posedge clk_in);
    op_valid_in <= 1'b0;
    #1;
    chk("mem_strobe", {10'h000, hit && wr, hit && !wr}, {10'h000, mem_wr_out, mem_rd_out});
    if (hit)
    begin
      chk("mem_addr", ea, mem_addr_out);
      if (wr)
      begin
        chk("mem_wdata", {4'h0, wd}, {4'h0, mem_wdata_out});
      end
    end
    @(posedge clk_in);
    #1;
    chk("rsp_valid", {11'h000, ~wr}, {11'h000, rsp_valid_out});
    if (!wr)
    begin
      chk("rsp_data", {4'h0, rd}, {4'h0, rsp_data_out});
    end
  endtask

  // Loads a pair through its direct high and low register addresses.
  task automatic wp(input logic [7:0] lo_f, input logic [7:0] hi, input logic [7:0] lo);
    do_op(1'b1, 1'b0, lo_f + 8'h01, hi, 1'b0, 12'h000, 8'h00);
    do_op(1'b1, 1'b0, lo_f, lo, 1'b0, 12'h000, 8'h00);
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  initial
  begin
    repeat (3000) @(posedge clk_in);
    n_errors++;
    stop_test();
  end

  initial
  begin
    n_errors = 0;
    checked = 0;
    rst_n_in = 1'b0;
    ext_in = 1'b0;
    page_in = 4'hF;
    acc_in = 8'h00;
    op_valid_in = 1'b0;
    op_write_in = 1'b0;
    op_bank_bit_in = 1'b0;
    op_file_in = 8'h00;
    op_wdata_in = 8'h00;
    op_long_in = 1'b0;
    op_long_addr_in = 12'h000;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk("ptr0_reset", PTR_RESET, ptr0);
    wp(8'hE9, 8'h31, 8'hFF);
    chk("ptr0", 12'h1FF, ptr0);
    do_op(1'b0, 1'b0, 8'hEE, 8'h00, 1'b1, 12'h1FF, pat(12'h1FF));
    chk("ptr0", 12'h200, ptr0);
    do_op(1'b0, 1'b0, 8'hED, 8'h00, 1'b1, 12'h200, pat(12'h200));
    chk("ptr0", 12'h1FF, ptr0);
    do_op(1'b0, 1'b0, 8'hEC, 8'h00, 1'b1, 12'h200, pat(12'h200));
    chk("ptr0", 12'h200, ptr0);
    do_op(1'b1, 1'b1, 8'hEF, 8'h3C, 1'b1, 12'h200, 8'h00);
    setcfg(1'b0, 4'h7, 8'hFE);
    do_op(1'b0, 1'b0, 8'hEF, 8'h00, 1'b1, 12'h200, 8'h3C);
    do_op(1'b0, 1'b0, 8'hEB, 8'h00, 1'b1, 12'h1FE, pat(12'h1FE));
    setcfg(1'b0, 4'h2, 8'h7F);
    do_op(1'b0, 1'b0, 8'hEB, 8'h00, 1'b1, 12'h27F, pat(12'h27F));
    chk("ptr0", 12'h200, ptr0);
    wp(8'hE9, 8'h0F, 8'hE7);
    do_op(1'b0, 1'b0, 8'hEF, 8'h00, 1'b0, 12'h000, NULL_DATA);
    do_op(1'b1, 1'b0, 8'hEF, 8'h55, 1'b0, 12'h000, 8'h00);
    chk("ptr1", 12'h000, ptr1);
    wp(8'hE1, 8'h0F, 8'hEA);
    do_op(1'b0, 1'b0, 8'hE7, 8'h00, 1'b0, 12'h000, 8'h0F);
    wp(8'hD9, 8'h0F, 8'hD9);
    do_op(1'b1, 1'b0, 8'hDD, 8'h44, 1'b0, 12'h000, 8'h00);
    chk("ptr2", 12'hF44, ptr2);
    do_op(1'b1, 1'b1, 8'h34, 8'h5A, 1'b1, 12'h234, 8'h00);
    do_op(1'b0, 1'b1, 8'h34, 8'h00, 1'b1, 12'h234, 8'h5A);
    setcfg(1'b1, 4'h3, 8'h00);
    wp(8'hD9, 8'h01, 8'h00);
    do_op(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 12'h100, pat(12'h100));
    do_op(1'b0, 1'b0, 8'h5F, 8'h00, 1'b1, 12'h15F, pat(12'h15F));
    do_op(1'b0, 1'b0, 8'h60, 8'h00, 1'b1, 12'hF60, pat(12'hF60));
    do_op(1'b0, 1'b1, 8'h10, 8'h00, 1'b1, 12'h310, pat(12'h310));
    do_op(1'b0, 1'b0, 8'hDF, 8'h00, 1'b1, 12'h100, pat(12'h100));
    wp(8'hE9, 8'h02, 8'h34);
    do_op(1'b0, 1'b0, 8'hEF, 8'h00, 1'b1, 12'h234, 8'h5A);
    set_long(1'b1, 12'hFE9);
    do_op(1'b0, 1'b1, 8'h00, 8'h00, 1'b0, 12'h000, 8'h34);
    set_long(1'b1, 12'hFE1);
    do_op(1'b1, 1'b1, 8'h00, 8'h77, 1'b0, 12'h000, 8'h00);
    chk("ptr1", 12'hF77, ptr1);
    set_long(1'b0, 12'h000);
    stop_test();
  end
endmodule
`default_nettype wire
